// file: dv/t16c_pad_model.sv
// Port pad model for the two compare output pins.
// Assumes out and enable come straight from the timer; the pads have no pull.
module t16c_pad_model (
    // Clock and pin drive
    input wire logic clk_sys,
    input wire logic out_a,
    input wire logic oe_a,
    input wire logic out_b,
    input wire logic oe_b,
    // Pad levels
    output logic pad_a,
    output logic pad_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_a = 1'b0;
    logic last_b = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Remember the last driven level; a released pad must not keep it
    always_ff @(posedge clk_sys) begin
        if (oe_a) last_a <= out_a;
        if (oe_b) last_b <= out_b;
    end
    // Floating pad shows the inverse, so a stale value never passes
    assign pad_a = oe_a ? out_a : ~last_a;
    assign pad_b = oe_b ? out_b : ~last_b;
endmodule : t16c_pad_model

// file: dv/tb.sv
// Self-checking bench of the timer: APB driver, read scoreboard, pin checks.
// Assumes the pad model beside it and the constants header on the path.
`include "t16c_consts.svh"
`define T16C_CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end

module tb import t16c_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [4:0] pls = 5'h00;
    logic [31:0] prdata;
    logic pready, pslverr, pa, pa_oe, pb, pb_oe, pad_a, pad_b;
    logic [3:0] flg;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'h22BDFF7A;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic err_q[$];
    logic [31:0] rnd;
    int md[7] = '{4, 4, 4, 4, 4, 4, 12};
    int top[7] = '{0, 3, 1, 0, 0, 0, 2};
    int psc[7] = '{1, 1, 2, 3, 4, 5, 1};
    int fct[7] = '{1, 1, 8, 64, 256, 1024, 1};
    int com_ord[4] = '{0, 2, 3, 1};
    int st_ord[4] = '{1, 0, 1, 0};

    t16c_top u_t16c_top (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ovf_ack(pls[0]), .cmpa_ack(pls[1]), .cmpb_ack(pls[2]),
        .capt_ack(pls[3]), .capt_event(pls[4]), .overflow_flag(flg[0]),
        .compare_a_flag(flg[1]), .compare_b_flag(flg[2]), .capture_flag(flg[3]),
        .pin_a_out(pa), .pin_a_oe(pa_oe), .pin_b_out(pb), .pin_b_oe(pb_oe));
    t16c_pad_model u_t16c_pad_model (.clk_sys(clk_sys), .out_a(pa), .oe_a(pa_oe),
        .out_b(pb), .oe_b(pb_oe), .pad_a(pad_a), .pad_b(pad_b));

    always #12.5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // Hang guard, well above the longest run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            stop_test();
        end
    end

    // One APB transfer; held until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the hang guard ends a wait that never sees pready
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // Read: note the expectation, the monitor compares it
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
            input logic er = 1'b0);
        exp_q.push_back(e);
        msk_q.push_back(m);
        err_q.push_back(er);
        apb(1'b0, a, 32'h00000000);
    endtask : rd

    // Scoreboard: oldest note against each completed read
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            `T16C_CHK(prdata & msk_q[0], exp_q[0])
            `T16C_CHK(pslverr, err_q[0])
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
            void'(err_q.pop_front());
        end
    end

    // One-cycle pulse on an acknowledge or the capture trigger
    task pulse(input int i);
        @(posedge clk_sys);
        pls[i] <= 1'b1;
        @(posedge clk_sys);
        pls[i] <= 1'b0;
    endtask : pulse

    task pad(input logic sel_b, input logic e);
        @(posedge clk_sys);
        `T16C_CHK(sel_b ? pad_b : pad_a, e)
    endtask : pad

    // Clocks between two pad A toggles; the first wait only synchronises
    task period(input int e);
        logic last;
        int n;
        for (int k = 0; k < 2; k++) begin
            last = pad_a;
            n = 0;
            while (pad_a === last && n < 5000) begin
                @(posedge clk_sys);
                n++;
            end
        end
        `T16C_CHK(n, e)
    endtask : period

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(12'(4 * i), 32'h0);
        rd(12'h020, 32'h0, 32'hFFFFFFFF, 1'b1);
        rd(12'h002, 32'h0, 32'hFFFFFFFF, 1'b1);
        // Preset the state before the pin is enabled
        wr(`T16C_OFF_CTRL, 32'h30);
        wr(`T16C_OFF_FORCE, 32'h1);
        rd(`T16C_OFF_PORT, 32'h10);
        rd(`T16C_OFF_FLAGS, 32'h0);
        rd(`T16C_OFF_COUNT, 32'h0);
        wr(`T16C_OFF_PORT, 32'h2);
        pad(1'b0, 1'b1);
        wr(`T16C_OFF_CTRL, 32'h0);
        pad(1'b0, 1'b0);
        // Every compare action through the force strobe
        for (int i = 0; i < 4; i++) begin
            wr(`T16C_OFF_CTRL, 32'(com_ord[i]) << `T16C_CTRL_COMA_LSB);
            wr(`T16C_OFF_FORCE, 32'h1);
            rd(`T16C_OFF_PORT, 32'h2 | (32'(st_ord[i]) << 4));
        end
        rnd = $random(seed);
        wr(`T16C_OFF_PORT, 32'hA | (32'(rnd[0]) << 2));
        pad(1'b1, rnd[0]);
        wr(`T16C_OFF_CMPB, 32'h4000 | rnd[13:0]);
        rd(`T16C_OFF_CMPB, 32'h4000 | rnd[13:0]);
        // Capture with the timer stopped; interval stays in range
        wr(`T16C_OFF_CTRL, 32'h30);
        wr(`T16C_OFF_COUNT, rnd[31:16]);
        pulse(4);
        rd(`T16C_OFF_CAPT, rnd[31:16]);
        rd(`T16C_OFF_FLAGS, 32'h8);
        pulse(3);
        rd(`T16C_OFF_FLAGS, 32'h0);
        // Free running past a match and through the wrap
        wr(`T16C_OFF_CTRL, 32'h0);
        wr(`T16C_OFF_CMPA, 32'h4);
        wr(`T16C_OFF_COUNT, 32'hFFF8);
        wr(`T16C_OFF_CTRL, 32'h100);
        repeat (25) @(posedge clk_sys);
        wr(`T16C_OFF_CTRL, 32'h0);
        rd(`T16C_OFF_COUNT, 32'h10, 32'hFFF8);
        rd(`T16C_OFF_FLAGS, 32'h3);
        `T16C_CHK(flg, 4'h3)
        pulse(0);
        rd(`T16C_OFF_FLAGS, 32'h2);
        pulse(1);
        rd(`T16C_OFF_FLAGS, 32'h0);
        // Toggle periods; TOP only changed while stopped
        for (int i = 0; i < 7; i++) begin
            wr(`T16C_OFF_CTRL, 32'h10 | md[i]);
            wr(`T16C_OFF_COUNT, 32'hFFFF);
            wr(`T16C_OFF_CMPA, (md[i] == 12) ? 32'h0 : 32'(top[i]));
            wr(`T16C_OFF_CAPT, 32'(top[i]));
            wr(`T16C_OFF_CTRL, 32'h10 | md[i] | (32'(psc[i]) << `T16C_CTRL_PSC_LSB));
            period(fct[i] * (1 + top[i]));
        end
        wr(`T16C_OFF_CTRL, 32'h0);
        rd(`T16C_OFF_FLAGS, 32'hB);
        `T16C_CHK(flg, 4'hB)
        wr(`T16C_OFF_FLAGS, 32'hF);
        rd(`T16C_OFF_FLAGS, 32'h0);
        // Channel B: force preset, then a real match clears it and flags
        wr(`T16C_OFF_CTRL, 32'hC0);
        wr(`T16C_OFF_FORCE, 32'h2);
        pad(1'b1, 1'b1);
        wr(`T16C_OFF_CMPB, 32'h4);
        wr(`T16C_OFF_COUNT, 32'h3);
        wr(`T16C_OFF_CTRL, 32'h180);
        repeat (4) @(posedge clk_sys);
        wr(`T16C_OFF_CTRL, 32'h80);
        pad(1'b1, 1'b0);
        rd(`T16C_OFF_FLAGS, 32'h4);
        `T16C_CHK(flg, 4'h4)
        stop_test();
    end
endmodule : tb

// file: rtl/t16c_consts.svh
// Constants of the 16-bit timer compare-output block: register offsets,
// field positions, reset values and prescaler figures.
// Assumes inclusion by bare name from the package and the design file.
`ifndef T16C_CONSTS_SVH
`define T16C_CONSTS_SVH

// Register byte offsets on the APB
`define T16C_OFF_CTRL 12'h000
`define T16C_OFF_COUNT 12'h004
`define T16C_OFF_CMPA 12'h008
`define T16C_OFF_CMPB 12'h00C
`define T16C_OFF_CAPT 12'h010
`define T16C_OFF_FLAGS 12'h014
`define T16C_OFF_FORCE 12'h018
`define T16C_OFF_PORT 12'h01C

// Control register fields
`define T16C_CTRL_WGM_LSB 0
`define T16C_CTRL_COMA_LSB 4
`define T16C_CTRL_COMB_LSB 6
`define T16C_CTRL_PSC_LSB 8

// Flag register bit positions
`define T16C_FLG_OVF 0
`define T16C_FLG_CMPA 1
`define T16C_FLG_CMPB 2
`define T16C_FLG_CAPT 3

// Port register bit positions
`define T16C_PRT_VAL_A 0
`define T16C_PRT_DIR_A 1
`define T16C_PRT_VAL_B 2
`define T16C_PRT_DIR_B 3
`define T16C_PRT_OC_A 4
`define T16C_PRT_OC_B 5

// Reset values and counter limits
`define T16C_RST_CTRL 11'h000
`define T16C_RST_WORD 16'h0000
`define T16C_CNT_MAX 16'hFFFF
`define T16C_CNT_BOTTOM 16'h0000

// Waveform mode codes handled here
`define T16C_WGM_NORMAL 4'h0
`define T16C_WGM_CTC_CMPA 4'h4
`define T16C_WGM_CTC_CAPT 4'hC

// Prescaler terminal counts (factor minus one)
`define T16C_PSC_DIV1 10'h000
`define T16C_PSC_DIV8 10'h007
`define T16C_PSC_DIV64 10'h03F
`define T16C_PSC_DIV256 10'h0FF
`define T16C_PSC_DIV1024 10'h3FF

`endif

// file: rtl/t16c_pkg.sv
// Types of the 16-bit timer compare-output block.
// Assumes the constants header sits beside it on the include path.
`include "t16c_consts.svh"

package t16c_pkg;
    // Action on the compare output state at a match
    typedef enum logic [1:0] {
        T16C_COM_NONE = 2'h0,
        T16C_COM_TOGGLE = 2'h1,
        T16C_COM_CLEAR = 2'h2,
        T16C_COM_SET = 2'h3
    } t16c_com_type;
    typedef logic [15:0] t16c_word_type;
endpackage : t16c_pkg

// file: rtl/t16c_top.sv
// 16-bit timer with compare-output pin override, Normal and
// clear-on-match counting, APB register access.
// Assumes one 40 MHz clock, synchronous inputs, port pin pads outside.
//
// The APB register port and the address map were chosen for this implementation.
`include "t16c_consts.svh"

// Operation
// RQ1: Reset clears both compare output state registers to zero.
// RQ2: Nonzero compare mode replaces the port value on the pin with state.
// RQ3: The state shows on the pin only when the direction bit is output.
// RQ4: Software may force the state before enabling the pin direction.
// RQ5: Compare mode bits never affect the capture logic.
// RQ6: Compare mode zero leaves the state unchanged at a match.
// RQ7: New compare mode acts at next match; force strobe acts at once.
// RQ8: Counting depends on waveform mode only, never on compare mode.
// RQ9: Mode 0 always increments, never clears, wraps 0xFFFF to 0x0000.
// RQ10: Overflow flag sets when counter becomes zero; counting never clears it.
// RQ11: Overflow interrupt acknowledge clears the overflow flag.
// RQ12: In free-running mode software may write the counter any time.
// RQ13: Clear-on-match resets counter at compare A (mode 4) or capture (12).
// RQ14: TOP is not double buffered; a low TOP wraps through 0xFFFF first.
// RQ15: Reaching TOP sets the flag belonging to the TOP register.
// RQ16: Toggle mode inverts output A on every match, fastest at TOP zero.
// RQ17: Toggle rate is clock over 2, prescale factor and one plus TOP.
// RQ18: In clear-on-match mode overflow sets on the MAX to zero roll.
// RQ19: Software wanting glitch-safe TOP should use buffered PWM mode 15.
// RQ20: Software keeps capture intervals within the counter range.
// RQ21: Compare match sets its flag on the timer tick after detection.
// RQ22: Force updates the state only; no flag, no counter clear.
module t16c_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt acknowledges and capture trigger
    input wire logic ovf_ack,
    input wire logic cmpa_ack,
    input wire logic cmpb_ack,
    input wire logic capt_ack,
    input wire logic capt_event,
    // Flag levels
    output logic overflow_flag,
    output logic compare_a_flag,
    output logic compare_b_flag,
    output logic capture_flag,
    // Compare output pins
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe
);
    import t16c_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Next compare output state for a given action
    function automatic logic com_apply(input t16c_com_type com, input logic st);
        unique case (com)
            T16C_COM_NONE: com_apply = st;
            T16C_COM_TOGGLE: com_apply = ~st;
            T16C_COM_CLEAR: com_apply = 1'b0;
            T16C_COM_SET: com_apply = 1'b1;
        endcase
    endfunction : com_apply

    // Non-PWM modes are the only ones where force and match actions apply here
    function automatic logic non_pwm(input logic [3:0] wgm);
        non_pwm = (wgm == `T16C_WGM_NORMAL) || (wgm == `T16C_WGM_CTC_CMPA)
                  || (wgm == `T16C_WGM_CTC_CAPT);
    endfunction : non_pwm

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [10:0] ctrl_r, ctrl_nxt;
    t16c_word_type cnt_r, cnt_nxt;
    t16c_word_type cmpa_r, cmpa_nxt;
    t16c_word_type cmpb_r, cmpb_nxt;
    t16c_word_type capt_r, capt_nxt;
    logic [3:0] flag_r, flag_nxt;
    logic [3:0] port_r, port_nxt;
    logic [1:0] oc_r, oc_nxt;
    logic blk_r, blk_nxt;
    logic [9:0] psc_r, psc_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic slverr_r, slverr_nxt;

    logic [3:0] wgm;
    t16c_com_type com_a, com_b;
    logic [2:0] psc_sel;
    logic [9:0] psc_lim;
    logic tick;
    logic wr_acc, rd_setup, mapped;
    logic wr_ctrl, wr_cnt, wr_cmpa, wr_cmpb, wr_capt, wr_flags, wr_force, wr_port;
    logic force_a, force_b;
    logic match_a, match_b, capt_top, ctc_clear, ovf_set;
    logic [3:0] flag_set, flag_clr;

    assign wgm = ctrl_r[`T16C_CTRL_WGM_LSB +: 4];
    assign com_a = t16c_com_type'(ctrl_r[`T16C_CTRL_COMA_LSB +: 2]);
    assign com_b = t16c_com_type'(ctrl_r[`T16C_CTRL_COMB_LSB +: 2]);
    assign psc_sel = ctrl_r[`T16C_CTRL_PSC_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // APB decode: zero wait states, read data captured in the setup cycle

    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `T16C_OFF_PORT);
    assign wr_ctrl = wr_acc && (paddr == `T16C_OFF_CTRL);
    assign wr_cnt = wr_acc && (paddr == `T16C_OFF_COUNT);
    assign wr_cmpa = wr_acc && (paddr == `T16C_OFF_CMPA);
    assign wr_cmpb = wr_acc && (paddr == `T16C_OFF_CMPB);
    assign wr_capt = wr_acc && (paddr == `T16C_OFF_CAPT);
    assign wr_flags = wr_acc && (paddr == `T16C_OFF_FLAGS);
    assign wr_force = wr_acc && (paddr == `T16C_OFF_FORCE);
    assign wr_port = wr_acc && (paddr == `T16C_OFF_PORT);
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = slverr_r;

    // Read mux and error flag, loaded in setup so data leaves a flip-flop
    always_comb begin
        prdata_nxt = prdata_r;
        slverr_nxt = slverr_r;
        if (psel && !penable) begin
            slverr_nxt = !mapped;
        end
        if (rd_setup) begin
            unique case (paddr)
                `T16C_OFF_CTRL: prdata_nxt = {21'h000000, ctrl_r};
                `T16C_OFF_COUNT: prdata_nxt = {16'h0000, cnt_r};
                `T16C_OFF_CMPA: prdata_nxt = {16'h0000, cmpa_r};
                `T16C_OFF_CMPB: prdata_nxt = {16'h0000, cmpb_r};
                `T16C_OFF_CAPT: prdata_nxt = {16'h0000, capt_r};
                `T16C_OFF_FLAGS: prdata_nxt = {28'h0000000, flag_r};
                `T16C_OFF_PORT: prdata_nxt = {26'h0000000, oc_r, port_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Plain software registers; TOP writes land at once, not buffered
    always_comb begin
        ctrl_nxt = wr_ctrl ? pwdata[10:0] : ctrl_r;
        cmpa_nxt = wr_cmpa ? pwdata[15:0] : cmpa_r; // RQ14
        cmpb_nxt = wr_cmpb ? pwdata[15:0] : cmpb_r;
        port_nxt = wr_port ? pwdata[3:0] : port_r;
        force_a = wr_force && pwdata[0] && non_pwm(wgm); // RQ7
        force_b = wr_force && pwdata[1] && non_pwm(wgm);
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: one-cycle timer tick every N system clocks

    always_comb begin
        unique case (psc_sel)
            3'h1: psc_lim = `T16C_PSC_DIV1;
            3'h2: psc_lim = `T16C_PSC_DIV8;
            3'h3: psc_lim = `T16C_PSC_DIV64;
            3'h4: psc_lim = `T16C_PSC_DIV256;
            default: psc_lim = `T16C_PSC_DIV1024;
        endcase
        tick = (psc_sel != 3'h0) && (psc_sel <= 3'h5) && (psc_r == psc_lim); // RQ17
        if (tick || psc_sel == 3'h0 || psc_sel > 3'h5) begin
            psc_nxt = 10'h000;
        end else begin
            psc_nxt = psc_r + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, matches, flags and compare output state

    // Matches are judged on the value held during the timer cycle, so the
    // flag appears one tick after the counter reaches the compare value.
    // A counter write blocks the match of the following tick.
    always_comb begin
        match_a = tick && !blk_r && (cnt_r == cmpa_r); // RQ21
        match_b = tick && !blk_r && (cnt_r == cmpb_r);
        capt_top = tick && !blk_r && (cnt_r == capt_r)
                   && (wgm == `T16C_WGM_CTC_CAPT);
        // Counting looks at the waveform mode only
        ctc_clear = ((wgm == `T16C_WGM_CTC_CMPA) && match_a) || capt_top; // RQ8 RQ13
        ovf_set = tick && !wr_cnt && (cnt_r == `T16C_CNT_MAX); // RQ10 RQ18
        cnt_nxt = cnt_r;
        if (wr_cnt) begin
            cnt_nxt = pwdata[15:0]; // RQ12
        end else if (ctc_clear) begin
            cnt_nxt = `T16C_CNT_BOTTOM; // RQ13
        end else if (tick) begin
            cnt_nxt = cnt_r + 16'h0001; // RQ9 RQ14
        end
        blk_nxt = wr_cnt ? 1'b1 : (tick ? 1'b0 : blk_r);
    end

    // Capture loads only outside mode 12, never looking at compare mode
    always_comb begin
        capt_nxt = capt_r; // RQ5
        if (wr_capt) begin
            capt_nxt = pwdata[15:0];
        end else if (capt_event && wgm != `T16C_WGM_CTC_CAPT) begin
            capt_nxt = cnt_r;
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins
    always_comb begin
        flag_set = 4'h0;
        flag_set[`T16C_FLG_OVF] = ovf_set; // RQ10
        flag_set[`T16C_FLG_CMPA] = match_a; // RQ15 RQ21
        flag_set[`T16C_FLG_CMPB] = match_b; // RQ21
        flag_set[`T16C_FLG_CAPT] = capt_top
                                   || (capt_event && wgm != `T16C_WGM_CTC_CAPT); // RQ15
        flag_clr = (wr_flags ? pwdata[3:0] : 4'h0)
                   | {capt_ack, cmpb_ack, cmpa_ack, ovf_ack}; // RQ11
        flag_nxt = flag_set | (flag_r & ~flag_clr);
    end

    // Output state: action taken from the compare mode at match time, so a
    // new mode acts at the first match after its write; force acts at once
    // and leaves flags and counter alone.
    always_comb begin
        oc_nxt = oc_r;
        if (force_a || (match_a && non_pwm(wgm))) begin
            oc_nxt[0] = com_apply(com_a, oc_r[0]); // RQ6 RQ7 RQ16 RQ22
        end
        if (force_b || (match_b && non_pwm(wgm))) begin
            oc_nxt[1] = com_apply(com_b, oc_r[1]); // RQ6 RQ7 RQ22
        end
    end

    // Pin override: state replaces the port value, direction stays with
    // the port bit, so software can preset the state while the pin is off
    always_comb begin
        pin_a_out = (com_a != T16C_COM_NONE) ? oc_r[0] : port_r[`T16C_PRT_VAL_A]; // RQ2
        pin_b_out = (com_b != T16C_COM_NONE) ? oc_r[1] : port_r[`T16C_PRT_VAL_B]; // RQ2
        pin_a_oe = port_r[`T16C_PRT_DIR_A]; // RQ3 RQ4
        pin_b_oe = port_r[`T16C_PRT_DIR_B]; // RQ3
    end

    assign overflow_flag = flag_r[`T16C_FLG_OVF];
    assign compare_a_flag = flag_r[`T16C_FLG_CMPA];
    assign compare_b_flag = flag_r[`T16C_FLG_CMPB];
    assign capture_flag = flag_r[`T16C_FLG_CAPT];

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r <= `T16C_RST_CTRL;
            cnt_r <= `T16C_RST_WORD;
            cmpa_r <= `T16C_RST_WORD;
            cmpb_r <= `T16C_RST_WORD;
            capt_r <= `T16C_RST_WORD;
            flag_r <= 4'h0;
            port_r <= 4'h0;
            oc_r <= 2'h0; // RQ1
            blk_r <= 1'b0;
            psc_r <= 10'h000;
            prdata_r <= 32'h00000000;
            slverr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            cmpa_r <= cmpa_nxt;
            cmpb_r <= cmpb_nxt;
            capt_r <= capt_nxt;
            flag_r <= flag_nxt;
            port_r <= port_nxt;
            oc_r <= oc_nxt;
            blk_r <= blk_nxt;
            psc_r <= psc_nxt;
            prdata_r <= prdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    pin_override_a: assert property ( // RQ2
        com_a != T16C_COM_NONE |-> pin_a_out == oc_r[0])
        else $error("pin A does not show compare state");
    pin_enable_a: assert property ( // RQ3
        !port_r[`T16C_PRT_DIR_A] |-> !pin_a_oe)
        else $error("pin A driven while direction is input");
    com_zero_hold_a: assert property ( // RQ6
        match_a && com_a == T16C_COM_NONE && !wr_force |=> $stable(oc_r[0]))
        else $error("compare state moved with mode zero");
    normal_wrap_a: assert property ( // RQ9
        tick && wgm == `T16C_WGM_NORMAL && !wr_cnt && cnt_r == `T16C_CNT_MAX
        |=> cnt_r == `T16C_CNT_BOTTOM && overflow_flag)
        else $error("normal mode wrap or overflow wrong");
    ovf_set_a: assert property ( // RQ10
        ovf_set |=> overflow_flag ##0 $past(cnt_nxt) == `T16C_CNT_BOTTOM)
        else $error("overflow flag missing on roll to zero");
    ovf_ack_a: assert property ( // RQ11
        overflow_flag && ovf_ack && !ovf_set |=> !overflow_flag)
        else $error("acknowledge did not clear overflow");
    cnt_write_a: assert property ( // RQ12
        wr_cnt |=> cnt_r == $past(pwdata[15:0]))
        else $error("counter write lost");
    ctc_clear_a: assert property ( // RQ13
        tick && !wr_cnt && !blk_r && wgm == `T16C_WGM_CTC_CMPA && cnt_r == cmpa_r
        |=> cnt_r == `T16C_CNT_BOTTOM && compare_a_flag)
        else $error("clear-on-match did not clear at TOP");
    ctc_toggle_a: assert property ( // RQ16
        match_a && wgm == `T16C_WGM_CTC_CMPA && com_a == T16C_COM_TOGGLE && !wr_force
        |=> oc_r[0] != $past(oc_r[0]))
        else $error("toggle mode did not invert output A");
    force_noflag_a: assert property ( // RQ22
        force_a && !match_a && !compare_a_flag ##1 !match_a[*2]
        |-> !compare_a_flag && $stable(cnt_r) || $past(tick) || $past(wr_cnt))
        else $error("force changed flag or counter");

    // Channel B pin, reset state and forced actions
    reset_state_a: assert property ( // RQ1
        $fell(rst) |-> oc_r == 2'h0 && flag_r == 4'h0)
        else $error("compare state not cleared by reset");
    override_b_a: assert property ( // RQ2
        com_b != T16C_COM_NONE |-> pin_b_out == oc_r[1])
        else $error("pin B does not show compare state");
    enable_b_a: assert property ( // RQ3
        !port_r[`T16C_PRT_DIR_B] |-> !pin_b_oe)
        else $error("pin B driven while direction is input");
    force_action_a: assert property ( // RQ7
        force_a && com_a[1] |=> oc_r[0] == $past(com_a[0]))
        else $error("force did not set or clear output A");

    // Counting, capture, TOP writes and flag timing
    capt_load_a: assert property ( // RQ5
        capt_event && !wr_capt && wgm != `T16C_WGM_CTC_CAPT |=> capt_r == $past(cnt_r))
        else $error("capture did not load the counter");
    cnt_step_a: assert property ( // RQ8 RQ9
        tick && !wr_cnt && wgm == `T16C_WGM_NORMAL
        |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
        else $error("normal mode did not increment");
    ctc_capt_a: assert property ( // RQ13 RQ15
        tick && !wr_cnt && !blk_r && wgm == `T16C_WGM_CTC_CAPT && cnt_r == capt_r
        |=> cnt_r == `T16C_CNT_BOTTOM && capture_flag)
        else $error("capture TOP did not clear the counter");
    top_write_a: assert property ( // RQ14
        wr_cmpa |=> cmpa_r == $past(pwdata[15:0]))
        else $error("TOP write did not land at once");
    psc_stop_a: assert property ( // RQ17
        psc_sel == 3'h0 || psc_sel > 3'h5 |-> !tick)
        else $error("stopped prescaler still ticks");
    ctc_ovf_a: assert property ( // RQ18
        tick && !wr_cnt && wgm == `T16C_WGM_CTC_CMPA && cnt_r == `T16C_CNT_MAX
        |=> overflow_flag)
        else $error("clear-on-match roll did not set overflow");
    cmpb_flag_a: assert property ( // RQ21
        match_b |=> compare_b_flag)
        else $error("compare B flag missing after match");

    ctc_toggle_c: cover property (
        match_a && wgm == `T16C_WGM_CTC_CMPA && com_a == T16C_COM_TOGGLE);
    normal_ovf_c: cover property (ovf_set && wgm == `T16C_WGM_NORMAL);
    force_c: cover property (force_a ##1 pin_a_oe);
    capt_top_c: cover property (capt_top);

endmodule : t16c_top
